// ### pkg/tmr_cnt_if.sv
// Purpose: Load and status wires between the access logic and one counter.
// Assumes: Single clock domain.
// Notes:   Load of the counter has priority over counting.
`timescale 1ns/1ps
interface tmr_cnt_if;
	logic                           en;
	logic                           ld_cnt;
	logic                           ld_rel;
	logic [tmr_pkg::TMR_W-1:0]      ld_val;
	logic [tmr_pkg::TMR_W-1:0]      cnt;
	logic [tmr_pkg::TMR_W-1:0]      rel;
	logic                           uf;
	modport unit (input en, ld_cnt, ld_rel, ld_val, output cnt, rel, uf);
	modport ctl (output en, ld_cnt, ld_rel, ld_val, input cnt, rel, uf);
endinterface

// ### pkg/tmr_pkg.sv
// Purpose: Shared constants for the timer access and flag skip block.
// Assumes: 32-bit word-aligned slave, byte address, 4-bit nibble fields.
// Notes:   Writes carry {aux, acc} in writedata[7:4] and writedata[3:0].
// Behaviour
// RULE1 - Prescaler read returns upper nibble as aux and lower as acc.
// RULE2 - Prescaler write loads aux/acc into both counter and reload.
// RULE3 - Reading any timer returns current count as aux and acc nibbles.
// RULE4 - Timer 1 write loads the byte into counter and reload register.
// RULE5 - Timer 2 write loads the byte into counter and reload register.
// RULE6 - Timer 3 write loads the byte into counter and reload register.
// RULE7 - Timer 4 write loads the byte into counter and low reload register.
// RULE8 - A separate write loads only timer 4 high reload, counter untouched.
// RULE9 - Timer 1 reload-only write updates reload, counter untouched.
// RULE10 - Timer 3 reload-only write updates reload, counter untouched.
// RULE11 - A command copies timer 4 low reload into the timer 4 counter.
// RULE12 - Timer 1 skip test: enable bit clear and flag set skips, clears.
// RULE13 - Timer 2 skip test: enable bit clear and flag set skips, clears.
// RULE14 - Timer 3 skip test: enable bit clear and flag set skips, clears.
// RULE15 - Timer 4 skip test: enable bit clear and flag set skips, clears.
// RULE16 - Timer control register five reads and writes as four bits.
// RULE17 - Timer control register six reads and writes as four bits.
// RULE18 - Timer control registers one to four read and write as values.
// RULE19 - Timers count down on ticks, reload and set flag on underflow.
package tmr_pkg;
	localparam int TMR_W = 8;
	localparam int NIB_W = 4;
	localparam int ADDR_W = 8;
	// Word indices; the byte address is four times the index.
	localparam logic [5:0] IDX_PS = 6'h00;
	localparam logic [5:0] IDX_T1 = 6'h01;
	localparam logic [5:0] IDX_T2 = 6'h02;
	localparam logic [5:0] IDX_T3 = 6'h03;
	localparam logic [5:0] IDX_T4 = 6'h04;
	localparam logic [5:0] IDX_T4H = 6'h05;
	localparam logic [5:0] IDX_T1R = 6'h06;
	localparam logic [5:0] IDX_T3R = 6'h07;
	localparam logic [5:0] IDX_T4CP = 6'h08;
	localparam logic [5:0] IDX_SKIP = 6'h09;
	localparam logic [5:0] IDX_CTRL = 6'h0D;
	localparam logic [5:0] IDX_V1 = 6'h13;
	localparam logic [5:0] IDX_V2 = 6'h14;
	localparam logic [5:0] IDX_STAT = 6'h15;
	localparam logic [5:0] IDX_MASK = 6'h16;
	// Enable bit positions for the timer flags in the two int controls.
	localparam int POS_T1_EN = 2;
	localparam int POS_T2_EN = 3;
	localparam int POS_T3_EN = 0;
	localparam int POS_T4_EN = 1;
	localparam int POS_RUN = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_NIB = 4'h0;
endpackage

// ### sim/timer_access_and_flag_skip_tb_top.sv
// Purpose: Self-checking bench for the timer access and flag skip block.
// Assumes: Timers stay stopped until a scenario sets their run bit.
// Notes:   All bus traffic goes through the core-side model.
`timescale 1ns/1ps
module timer_access_and_flag_skip_tb_top;
	logic        clk;
	logic        sys_rst;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        irq;
	int          fail_count;
	int          n_compared;

	tmr_access dut_u (.clk(clk), .sys_rst(sys_rst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .irq(irq));
	tmr_cpu_model cpu_u (.clk(clk), .readdata(readdata),
		.waitrequest(waitrequest), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] b);
		logic ok;
		cpu_u.aux_q = b[7:4];
		cpu_u.acc_q = b[3:0];
		cpu_u.xfer(1'b1, idx, ok);
		if (!ok)
			chk(8'h00, 8'hFF);
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
		logic ok;
		cpu_u.xfer(1'b0, idx, ok);
		chk(ok ? {cpu_u.aux_q, cpu_u.acc_q} : ~exp, exp);
	endtask

	task automatic t_timers();
		for (int i = 0; i < 4; i++)
			wr(6'(tmr_pkg::IDX_T1 + i), 8'h2C + 8'(17 * i)); // 7
		for (int i = 0; i < 4; i++)
			rd(6'(tmr_pkg::IDX_T1 + i), 8'h2C + 8'(17 * i));
		rd(6'h3F, 8'h00);
	endtask

	task automatic t_reload_only();
		wr(tmr_pkg::IDX_T1R, 8'h3C);
		rd(tmr_pkg::IDX_T1, 8'h2C);
		rd(tmr_pkg::IDX_T1R, 8'h3C);
		wr(tmr_pkg::IDX_T3R, 8'h7A);
		rd(tmr_pkg::IDX_T3, 8'h4E);
		rd(tmr_pkg::IDX_T3R, 8'h7A);
		wr(tmr_pkg::IDX_T4H, 8'h96);
		rd(tmr_pkg::IDX_T4, 8'h5F);
		rd(tmr_pkg::IDX_T4H, 8'h96);
		rd(tmr_pkg::IDX_T4CP, 8'h5F);
	endtask

	// The prescaler runs freely, so its count may have moved a few steps.
	task automatic t_prescaler();
		logic       ok;
		logic [7:0] got;
		wr(tmr_pkg::IDX_PS, 8'hC3);
		cpu_u.xfer(1'b0, tmr_pkg::IDX_PS, ok);
		got = {cpu_u.aux_q, cpu_u.acc_q};
		chk(ok && got <= 8'hC3 && got >= 8'hBD, 8'h01);
		wr(tmr_pkg::IDX_PS, 8'h00);
	endtask

	task automatic t_ctrl();
		for (int i = 0; i < 6; i++)
			wr(6'(tmr_pkg::IDX_CTRL + i), 8'(2 * i + 2)); // 18
		for (int i = 0; i < 6; i++)
			rd(6'(tmr_pkg::IDX_CTRL + i), 8'(2 * i + 2)); // 18
	endtask

	task automatic t_copy();
		wr(tmr_pkg::IDX_T4, 8'h12);
		wr(tmr_pkg::IDX_CTRL + 6'h03, 8'h01);
		repeat (6) @(posedge clk);
		wr(tmr_pkg::IDX_CTRL + 6'h03, 8'h00);
		wr(tmr_pkg::IDX_T4CP, 8'hEE);
		rd(tmr_pkg::IDX_T4, 8'h12);
	endtask

	task automatic t_flags();
		for (int i = 0; i < 4; i++)
		begin
			wr(6'(tmr_pkg::IDX_T1 + i), 8'h01);
			wr(6'(tmr_pkg::IDX_CTRL + i), 8'h01);
		end
		repeat (600) @(posedge clk);
		for (int i = 0; i < 4; i++)
			wr(6'(tmr_pkg::IDX_CTRL + i), 8'h00);
		repeat (10) @(posedge clk);
		rd(tmr_pkg::IDX_STAT, 8'h0F);
		wr(tmr_pkg::IDX_MASK, 8'h00);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
		wr(tmr_pkg::IDX_MASK, 8'h0F);
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h01);
	endtask

	task automatic t_skip();
		int         pos[4];
		logic [5:0] vreg;
		logic [7:0] rem;
		pos = '{tmr_pkg::POS_T1_EN, tmr_pkg::POS_T2_EN,
			tmr_pkg::POS_T3_EN, tmr_pkg::POS_T4_EN};
		rem = 8'h0F;
		for (int i = 0; i < 4; i++)
		begin
			vreg = (i < 2) ? tmr_pkg::IDX_V1 : tmr_pkg::IDX_V2;
			wr(vreg, 8'h01 << pos[i]);
			rd(6'(tmr_pkg::IDX_SKIP + i), 8'h00); // 15
			rd(tmr_pkg::IDX_STAT, rem); // 15
			wr(vreg, 8'h00);
			rd(6'(tmr_pkg::IDX_SKIP + i), 8'h01); // 15
			rd(6'(tmr_pkg::IDX_SKIP + i), 8'h00); // 15
			rem = rem & ~(8'h01 << i);
			rd(tmr_pkg::IDX_STAT, rem); // 15
		end
		repeat (3) @(posedge clk);
		chk({7'h00, irq}, 8'h00);
	endtask

	initial
	begin
		fail_count = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_timers();
		t_reload_only();
		t_prescaler();
		t_ctrl();
		t_copy();
		t_flags();
		t_skip();
		stop_test();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
endmodule

// ### sim/tmr_cpu_model.sv
// Purpose: Core-side model that holds the accumulator and auxiliary nibbles.
// Assumes: The block answers each request with waitrequest low.
// Notes:   Released address and data lines show inverted values.
`timescale 1ns/1ps
module tmr_cpu_model
(
	input  wire logic        clk,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	output logic [7:0]       address,
	output logic             read,
	output logic             write,
	output logic [31:0]      writedata,
	output logic [3:0]       byteenable
);
	logic [3:0] acc_q;
	logic [3:0] aux_q;

	initial
	begin
		address = 8'hFF;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'hF;
		acc_q = 4'h0;
		aux_q = 4'h0;
	end

	// A read loads aux from the upper nibble and acc from the lower one.
	task automatic xfer(input logic wr, input logic [5:0] idx, output logic ok);
		int n;
		@(posedge clk);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= {24'h000000, aux_q, acc_q};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 64);
		ok = (waitrequest === 1'b0);
		if (!wr && ok)
		begin
			aux_q = readdata[7:4];
			acc_q = readdata[3:0];
		end
		read <= 1'b0;
		write <= 1'b0;
		writedata <= ~{24'h000000, aux_q, acc_q};
		address <= ~{idx, 2'b00};
	endtask
endmodule

// ### src/tmr_access.sv
// Purpose: Nibble access to prescaler and four timers, flag skip tests.
// Assumes: Avalon-MM slave, 32-bit data, one answer per request.
// Notes:   Every request is answered with waitrequest low in the cycle
//          after it is first seen; reads show {aux, acc} in bits 7:0.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tmr_access
(
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic [tmr_pkg::ADDR_W-1:0] address,
	input  wire logic                       read,
	input  wire logic                       write,
	input  wire logic [31:0]                writedata,
	input  wire logic [3:0]                 byteenable,
	output logic [31:0]                     readdata,
	output logic                            waitrequest,
	output logic                            irq
);
	logic [31:0]                    readdata_q;
	logic                           waitrequest_q;
	logic                           acc;
	logic                           wr;
	logic                           rd;
	logic [5:0]                     idx;
	logic [tmr_pkg::TMR_W-1:0]      wv;
	logic [4:0]                     ld_cnt_v;
	logic [4:0]                     ld_rel_v;
	logic [tmr_pkg::TMR_W-1:0]      cnt_w [5];
	logic [tmr_pkg::TMR_W-1:0]      rel_w [5];
	logic [4:0]                     uf_w;
	logic [tmr_pkg::TMR_W-1:0]      rel4h_q;
	logic [3:0]                     ctrl_q [6];
	logic [3:0]                     v1_q;
	logic [3:0]                     v2_q;
	logic [3:0]                     mask_q;
	logic [3:0]                     flag_w;
	logic [3:0]                     en_bit;
	logic [3:0]                     skip_v;
	logic [3:0]                     clr_v;
	logic [3:0]                     irq_w;

	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;
	assign irq = irq_w[0];

	assign acc = (read | write) & waitrequest_q;
	assign wr = acc & write & byteenable[0];
	assign rd = acc & read;
	assign idx = address[tmr_pkg::ADDR_W-1:2];
	assign wv = writedata[tmr_pkg::TMR_W-1:0];

	// A request is taken once, then answered for exactly one cycle.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			waitrequest_q <= 1'b1;
		else if (acc)
			waitrequest_q <= 1'b0;
		else
			waitrequest_q <= 1'b1;
	end

	always_comb
	begin
		ld_cnt_v = 5'h00;
		ld_rel_v = 5'h00;
		if (wr)
		begin
			ld_cnt_v[0] = (idx == tmr_pkg::IDX_PS); // see RULE2
			ld_rel_v[0] = (idx == tmr_pkg::IDX_PS); // see RULE2
			ld_cnt_v[1] = (idx == tmr_pkg::IDX_T1); // see RULE4
			ld_rel_v[1] = (idx == tmr_pkg::IDX_T1) // see RULE4
				| (idx == tmr_pkg::IDX_T1R); // see RULE9
			ld_cnt_v[2] = (idx == tmr_pkg::IDX_T2); // see RULE5
			ld_rel_v[2] = (idx == tmr_pkg::IDX_T2); // see RULE5
			ld_cnt_v[3] = (idx == tmr_pkg::IDX_T3); // see RULE6
			ld_rel_v[3] = (idx == tmr_pkg::IDX_T3) // see RULE6
				| (idx == tmr_pkg::IDX_T3R); // see RULE10
			ld_cnt_v[4] = (idx == tmr_pkg::IDX_T4) // see RULE7
				| (idx == tmr_pkg::IDX_T4CP); // see RULE11
			ld_rel_v[4] = (idx == tmr_pkg::IDX_T4); // see RULE7
		end
	end

	// Index 0 is the prescaler, which runs on every clock; timers tick
	// on prescaler underflow while their run bit is set.
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1)
		begin : g_cnt
			tmr_cnt_if cif ();
			if (gi == 0)
			begin : g_ps
				assign cif.en = 1'b1;
			end
			else
			begin : g_tm
				assign cif.en = ctrl_q[gi-1][tmr_pkg::POS_RUN]
					& uf_w[0]; // see RULE19
			end
			assign cif.ld_cnt = ld_cnt_v[gi];
			assign cif.ld_rel = ld_rel_v[gi];
			assign cif.ld_val = (gi == 4 && idx == tmr_pkg::IDX_T4CP)
				? rel_w[4] : wv; // see RULE11
			assign cnt_w[gi] = cif.cnt;
			assign rel_w[gi] = cif.rel;
			assign uf_w[gi] = cif.uf;
			tmr_counter u_cnt
			(
				.clk     (clk),
				.sys_rst (sys_rst),
				.bus     (cif)
			);
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rel4h_q <= tmr_pkg::RST_BYTE;
		else if (wr && idx == tmr_pkg::IDX_T4H)
			rel4h_q <= wv; // see RULE8
	end

	generate
		for (gi = 0; gi < 6; gi = gi + 1)
		begin : g_ctrl
			always_ff @(posedge clk)
			begin
				if (sys_rst)
					ctrl_q[gi] <= tmr_pkg::RST_NIB;
				else if (wr && idx == tmr_pkg::IDX_CTRL + 6'(gi))
					ctrl_q[gi] <= wv[3:0]; // see RULE16 RULE17 RULE18
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			v1_q <= tmr_pkg::RST_NIB;
			v2_q <= tmr_pkg::RST_NIB;
			mask_q <= tmr_pkg::RST_NIB;
		end
		else if (wr)
		begin
			if (idx == tmr_pkg::IDX_V1)
				v1_q <= wv[3:0];
			if (idx == tmr_pkg::IDX_V2)
				v2_q <= wv[3:0];
			if (idx == tmr_pkg::IDX_MASK)
				mask_q <= wv[3:0];
		end
	end

	assign en_bit[0] = v1_q[tmr_pkg::POS_T1_EN]; // see RULE12
	assign en_bit[1] = v1_q[tmr_pkg::POS_T2_EN]; // see RULE13
	assign en_bit[2] = v2_q[tmr_pkg::POS_T3_EN]; // see RULE14
	assign en_bit[3] = v2_q[tmr_pkg::POS_T4_EN]; // see RULE15

	// A skip test is a read; bit 0 answers skip and the flag is cleared.
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_skip
			assign skip_v[gi] = rd && idx == tmr_pkg::IDX_SKIP + 6'(gi)
				&& !en_bit[gi] && flag_w[gi]; // see RULE12 RULE13
			assign clr_v[gi] = skip_v[gi] // see RULE14 RULE15
				| (wr && idx == tmr_pkg::IDX_STAT && wv[gi]);
		end
	endgenerate

	tmr_flags u_flags
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.set     (uf_w[4:1]),
		.clr     (clr_v),
		.mask    (mask_q),
		.flag    (flag_w),
		.irq     (irq_w[0])
	);
	assign irq_w[3:1] = 3'h0;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			readdata_q <= 32'h0000_0000;
		else if (rd)
		begin
			readdata_q <= 32'h0000_0000;
			if (idx <= tmr_pkg::IDX_T4)
				readdata_q[7:0] <= cnt_w[idx[2:0]]; // see RULE1 RULE3
			else if (idx == tmr_pkg::IDX_T4H)
				readdata_q[7:0] <= rel4h_q;
			else if (idx == tmr_pkg::IDX_T1R)
				readdata_q[7:0] <= rel_w[1];
			else if (idx == tmr_pkg::IDX_T3R)
				readdata_q[7:0] <= rel_w[3];
			else if (idx == tmr_pkg::IDX_T4CP)
				readdata_q[7:0] <= rel_w[4];
			else if (idx >= tmr_pkg::IDX_SKIP && idx < tmr_pkg::IDX_CTRL)
				readdata_q[0] <= |skip_v;
			else if (idx >= tmr_pkg::IDX_CTRL && idx < tmr_pkg::IDX_V1)
				readdata_q[3:0] <= ctrl_q[3'(idx - tmr_pkg::IDX_CTRL)];
			else if (idx == tmr_pkg::IDX_V1)
				readdata_q[3:0] <= v1_q;
			else if (idx == tmr_pkg::IDX_V2)
				readdata_q[3:0] <= v2_q;
			else if (idx == tmr_pkg::IDX_STAT)
				readdata_q[3:0] <= flag_w;
			else if (idx == tmr_pkg::IDX_MASK)
				readdata_q[3:0] <= mask_q;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_wait_answer: assert property (acc |=> !waitrequest_q
		##1 waitrequest_q)
		else $error("waitrequest did not pulse low for one cycle");
	a_ps_write_both: assert property ( // see RULE2
		wr && idx == tmr_pkg::IDX_PS |=> cnt_w[0] == $past(wv)
		&& rel_w[0] == $past(wv))
		else $error("prescaler write did not load count and reload");
	a_t1_write_both: assert property ( // see RULE4
		wr && idx == tmr_pkg::IDX_T1 |=> cnt_w[1] == $past(wv)
		&& rel_w[1] == $past(wv))
		else $error("timer 1 write did not load count and reload");
	a_t4_write_low: assert property ( // see RULE7
		wr && idx == tmr_pkg::IDX_T4 |=> cnt_w[4] == $past(wv)
		&& rel_w[4] == $past(wv))
		else $error("timer 4 write did not load count and low reload");
	a_t4h_only: assert property ( // see RULE8
		wr && idx == tmr_pkg::IDX_T4H |=> rel4h_q == $past(wv)
		&& $stable(rel_w[4]))
		else $error("timer 4 high reload write went wrong");
	a_t3_rel_only: assert property ( // see RULE10
		wr && idx == tmr_pkg::IDX_T3R && !uf_w[0] && !ld_cnt_v[3]
		|=> rel_w[3] == $past(wv) && $stable(cnt_w[3]))
		else $error("timer 3 reload-only write disturbed the counter");
	a_t4_copy: assert property ( // see RULE11
		wr && idx == tmr_pkg::IDX_T4CP |=> cnt_w[4] == $past(rel_w[4]))
		else $error("timer 4 copy from low reload failed");
	a_read_timer: assert property ( // see RULE3
		rd && idx == tmr_pkg::IDX_T2 |=> readdata_q[7:0] ==
		$past(cnt_w[2]) ##1 waitrequest_q)
		else $error("timer 2 read returned the wrong count");
	a_skip_clear: assert property ( // see RULE12
		rd && idx == tmr_pkg::IDX_SKIP && !v1_q[tmr_pkg::POS_T1_EN]
		&& flag_w[0] && !uf_w[1] |=> readdata_q[0] && !flag_w[0])
		else $error("timer 1 skip test did not skip and clear");
	a_skip_blocked: assert property ( // see RULE13
		rd && idx == tmr_pkg::IDX_SKIP + 6'h01
		&& v1_q[tmr_pkg::POS_T2_EN] |=> !readdata_q[0]
		&& flag_w[1] == $past(flag_w[1] | uf_w[2]))
		else $error("timer 2 skip test acted while its enable was set");
	a_ctrl_five: assert property ( // see RULE16
		wr && idx == tmr_pkg::IDX_CTRL + 6'h04 |=> ctrl_q[4] ==
		$past(wv[3:0]))
		else $error("timer control five write was lost");
	a_underflow: assert property ( // see RULE19
		uf_w[3] |-> cnt_w[3] == rel_w[3] || $past(ld_rel_v[3]))
		else $error("timer 3 did not reload on underflow");
	a_t2_write_both: assert property ( // see RULE5
		wr && idx == tmr_pkg::IDX_T2 |=> cnt_w[2] == $past(wv)
		&& rel_w[2] == $past(wv))
		else $error("timer 2 write did not load count and reload");
	a_t3_write_both: assert property ( // see RULE6
		wr && idx == tmr_pkg::IDX_T3 |=> cnt_w[3] == $past(wv)
		&& rel_w[3] == $past(wv))
		else $error("timer 3 write did not load count and reload");
	a_t1_rel_only: assert property ( // see RULE9
		wr && idx == tmr_pkg::IDX_T1R && !uf_w[0]
		|=> rel_w[1] == $past(wv) && $stable(cnt_w[1]))
		else $error("timer 1 reload-only write disturbed the counter");
	a_t4_copy_keep: assert property ( // see RULE11
		wr && idx == tmr_pkg::IDX_T4CP |=> $stable(rel_w[4]))
		else $error("timer 4 copy changed the low reload");
	a_read_ps: assert property ( // see RULE1
		rd && idx == tmr_pkg::IDX_PS |=> readdata_q[7:0] ==
		$past(cnt_w[0]) && readdata_q[31:8] == 24'h000000)
		else $error("prescaler read returned the wrong count");
	a_read_t4: assert property ( // see RULE3
		rd && idx == tmr_pkg::IDX_T4 |=> readdata_q[7:0] ==
		$past(cnt_w[4]))
		else $error("timer 4 read returned the wrong count");
	a_read_unmapped: assert property ( // see RULE3
		rd && idx > tmr_pkg::IDX_MASK |=> readdata_q == 32'h0000_0000)
		else $error("unmapped read did not return zero");
	a_be_refused: assert property ( // see RULE4
		write && waitrequest_q && !byteenable[0]
		|=> $stable(rel_w[1]) && $stable(rel4h_q))
		else $error("write without byte enable changed a register");
	a_skip_t2: assert property ( // see RULE13
		rd && idx == tmr_pkg::IDX_SKIP + 6'h01
		&& !v1_q[tmr_pkg::POS_T2_EN] && flag_w[1] && !uf_w[2]
		|=> readdata_q[0] && !flag_w[1])
		else $error("timer 2 skip test did not skip and clear");
	a_skip_t3: assert property ( // see RULE14
		rd && idx == tmr_pkg::IDX_SKIP + 6'h02
		&& !v2_q[tmr_pkg::POS_T3_EN] && flag_w[2] && !uf_w[3]
		|=> readdata_q[0] && !flag_w[2])
		else $error("timer 3 skip test did not skip and clear");
	a_skip_t4: assert property ( // see RULE15
		rd && idx == tmr_pkg::IDX_SKIP + 6'h03
		&& !v2_q[tmr_pkg::POS_T4_EN] && flag_w[3] && !uf_w[4]
		|=> readdata_q[0] && !flag_w[3])
		else $error("timer 4 skip test did not skip and clear");
	a_skip_t1_held: assert property ( // see RULE12
		rd && idx == tmr_pkg::IDX_SKIP && v1_q[tmr_pkg::POS_T1_EN]
		|=> !readdata_q[0] && flag_w[0] == $past(flag_w[0] | uf_w[1]))
		else $error("timer 1 skip test acted while its enable was set");
	a_skip_t3_held: assert property ( // see RULE14
		rd && idx == tmr_pkg::IDX_SKIP + 6'h02
		&& v2_q[tmr_pkg::POS_T3_EN] |=> !readdata_q[0]
		&& flag_w[2] == $past(flag_w[2] | uf_w[3]))
		else $error("timer 3 skip test acted while its enable was set");
	a_skip_t4_held: assert property ( // see RULE15
		rd && idx == tmr_pkg::IDX_SKIP + 6'h03
		&& v2_q[tmr_pkg::POS_T4_EN] |=> !readdata_q[0]
		&& flag_w[3] == $past(flag_w[3] | uf_w[4]))
		else $error("timer 4 skip test acted while its enable was set");
	a_ctrl_six: assert property ( // see RULE17
		wr && idx == tmr_pkg::IDX_CTRL + 6'h05 |=> ctrl_q[5] ==
		$past(wv[3:0]))
		else $error("timer control six write was lost");
	a_ctrl_one: assert property ( // see RULE18
		wr && idx == tmr_pkg::IDX_CTRL |=> ctrl_q[0] ==
		$past(wv[3:0]))
		else $error("timer control one write was lost");
	a_irq_level: assert property ( // see RULE19
		1'b1 |=> irq_w[0] == $past(|(flag_w & mask_q)))
		else $error("interrupt level does not follow masked flags");

	// Covers show that the blocked test and a full flag set were reached.
	c_skip_blocked: cover property (rd && idx == tmr_pkg::IDX_SKIP
		&& v1_q[tmr_pkg::POS_T1_EN]);
	c_flags_all: cover property (flag_w == 4'hF);

	c_skip_taken: cover property (|skip_v);
	c_t4_underflow: cover property (uf_w[4] ##[1:20] irq);
	c_reload_only: cover property (wr && idx == tmr_pkg::IDX_T1R);
endmodule

// ### src/tmr_counter.sv
// Purpose: One 8-bit down-counter with its reload register.
// Assumes: Loads and ticks come from logic on the same clock.
// Notes:   Underflow is a one-cycle pulse one edge after the zero tick.
`timescale 1ns/1ps
module tmr_counter
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	tmr_cnt_if.unit                 bus
);
	logic [tmr_pkg::TMR_W-1:0]      cnt_q;
	logic [tmr_pkg::TMR_W-1:0]      rel_q;
	logic                           uf_q;

	assign bus.cnt = cnt_q;
	assign bus.rel = rel_q;
	assign bus.uf = uf_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rel_q <= tmr_pkg::RST_BYTE;
		else if (bus.ld_rel)
			rel_q <= bus.ld_val;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cnt_q <= tmr_pkg::RST_BYTE;
			uf_q <= 1'b0;
		end
		else
		begin
			uf_q <= 1'b0;
			if (bus.ld_cnt)
				cnt_q <= bus.ld_val;
			else if (bus.en)
			begin
				if (cnt_q == tmr_pkg::RST_BYTE)
				begin
					cnt_q <= rel_q; // see RULE19
					uf_q <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule

// ### src/tmr_flags.sv
// Purpose: Sticky timer flags with mask and one level interrupt.
// Assumes: Set and clear are one-cycle pulses on the same clock.
// Notes:   A set in the cycle of a clear wins; irq lags flags by one edge.
`timescale 1ns/1ps
module tmr_flags
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic [3:0]         set,
	input  wire logic [3:0]         clr,
	input  wire logic [3:0]         mask,
	output logic [3:0]              flag,
	output logic                    irq
);
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			flag <= tmr_pkg::RST_NIB;
		else
			flag <= (flag & ~clr) | set; // see RULE19
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(flag & mask);
	end
endmodule
